// ### hdl/cpg_consts.svh
/*
 * Constants of the clock output power gating block: group count,
 * shutdown scheme codes and synchroniser depth.
 * Assumes inclusion by bare name from design files.
 */
`ifndef CPG_CONSTS_SVH
`define CPG_CONSTS_SVH

// =====================================================================
// Output groups and shutdown schemes
// =====================================================================
`define CPG_NUM_GROUPS   3
`define CPG_SCHEME_W     2
`define CPG_SCHEME_NONE  2'h0
`define CPG_SCHEME_C     2'h1
`define CPG_SCHEME_BC    2'h2
`define CPG_SCHEME_ALL   2'h3

// =====================================================================
// Synchroniser
// =====================================================================
`define CPG_SYNC_STAGES  2

`endif

// ### hdl/cpg_pkg.sv
/*
 * Types of the clock output power gating block.
 * Assumes cpg_consts.svh is available on the include path.
 */
`include "cpg_consts.svh"

package cpg_pkg;

    // Speed selection states, one-hot
    typedef enum logic [1:0] {
        CPG_SPD_NOM  = 2'b01,
        CPG_SPD_HALF = 2'b10
    } cpg_speed_e;

    typedef logic [`CPG_SCHEME_W-1:0] cpg_scheme_t;

endpackage : cpg_pkg

// ### hdl/cpg_sync_if.sv
/*
 * Interface carrying a raw level into the synchroniser and the
 * synchronised level back out.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/1ps

interface cpg_sync_if;
    logic raw;
    logic synced;
    modport owner (output raw, input synced);
    modport sync  (input raw, output synced);
endinterface : cpg_sync_if

// ### hdl/cpg_sync.sv
/*
 * Two-flop level synchroniser with clock enable.
 * Assumes the raw level is asynchronous to clk_i.
 */
`timescale 1ns/1ps
`include "cpg_consts.svh"

module cpg_sync (
    // Clock, reset and enable
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic en_i,
    // Level path
    cpg_sync_if.sync  s
);
    logic [`CPG_SYNC_STAGES-1:0] stg_q;

    // =================================================================
    // Sync chain
    // =================================================================
    // First stage is read only by the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stg_q <= '0;
        end else if (en_i) begin
            stg_q <= {stg_q[`CPG_SYNC_STAGES-2:0], s.raw};
        end
    end

    assign s.synced = stg_q[`CPG_SYNC_STAGES-1];
endmodule : cpg_sync

// ### hdl/cpg_top.sv
/*
 * Output power gating of a PLL clock driver: per-group glitch-free
 * shutdown and seamless halving of all output frequencies.
 * Assumes clk_i runs at twice the nominal VCO clock; the pins are asynchronous.
 */
`timescale 1ns/1ps
`include "cpg_consts.svh"

module cpg_top #(
    parameter int NUM_GROUPS = `CPG_NUM_GROUPS
) (
    // Clock, reset and enable
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    input  wire logic                    en_i,
    // Power control pins
    input  wire logic [`CPG_SCHEME_W-1:0] output_group_off_i,
    input  wire logic                    half_speed_request_i,
    // Clock outputs
    output logic [NUM_GROUPS-1:0]        clk_out_o,
    output logic                         half_speed_o
);
    // =================================================================
    // Internal VCO clocks
    // =================================================================
    logic              div_q;    // Half-speed VCO clock
    logic              nom_q;    // Nominal-speed VCO clock (clk/2)
    logic [1:0]        phase_q;
    cpg_pkg::cpg_speed_e spd_q;
    logic              src_clk;
    logic              both_low;

    // Nominal is clk/2, half is clk/4, both from one counter
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_q <= 2'h0;
        end else if (en_i) begin
            phase_q <= phase_q + 2'h1;
        end
    end
    assign nom_q    = phase_q[0];
    assign div_q    = phase_q[1];   // Edge-aligned divide by two
    // Both VCO clocks low in the next state
    assign both_low = (phase_q == 2'h3);

    // =================================================================
    // Pin synchronisers
    // =================================================================
    cpg_sync_if sd_if[`CPG_SCHEME_W] ();
    cpg_sync_if hs_if ();
    logic [`CPG_SCHEME_W-1:0] scheme_s;
    logic hs_s;

    for (genvar g = 0; g < `CPG_SCHEME_W; g++) begin : g_sd
        assign sd_if[g].raw = output_group_off_i[g];
        assign scheme_s[g]  = sd_if[g].synced;
        cpg_sync u_sync (
            .clk_i  (clk_i),
            .nrst_i (nrst_i),
            .en_i   (en_i),
            .s      (sd_if[g])
        );
    end

    // Half-speed request synchronised only on half-speed clock rising edges
    assign hs_if.raw = half_speed_request_i;
    assign hs_s      = hs_if.synced;
    cpg_sync u_hs_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .en_i   (en_i && (phase_q == 2'h1)), // Rise of slow clock
        .s      (hs_if)
    );

    // =================================================================
    // Speed selection
    // =================================================================
    // Switch only when both VCO clocks are about to be low
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spd_q <= cpg_pkg::CPG_SPD_NOM;
        end else if (en_i && both_low) begin
            case (spd_q)
                cpg_pkg::CPG_SPD_NOM: begin
                    if (hs_s) begin
                        spd_q <= cpg_pkg::CPG_SPD_HALF;
                    end
                end
                cpg_pkg::CPG_SPD_HALF: begin
                    if (!hs_s) begin
                        spd_q <= cpg_pkg::CPG_SPD_NOM;
                    end
                end
                default: begin
                    spd_q <= cpg_pkg::CPG_SPD_NOM;
                end
            endcase
        end
    end

    // Source next value: the selected clock at next phase
    logic [1:0] phase_n;
    assign phase_n = phase_q + 2'h1;
    // Low pulse stretches / shrinks with source change
    assign src_clk = (spd_q == cpg_pkg::CPG_SPD_HALF) ? phase_n[1]
                                                       : phase_n[0];

    // =================================================================
    // Group enables
    // =================================================================
    logic [NUM_GROUPS-1:0] grp_on;
    always_comb begin
        grp_on = '1;
        case (scheme_s)
            `CPG_SCHEME_NONE: grp_on = '1;
            `CPG_SCHEME_C:    grp_on = {{(NUM_GROUPS-1){1'b1}}, 1'b0};
            `CPG_SCHEME_BC:   grp_on = {1'b1, {(NUM_GROUPS-1){1'b0}}};
            `CPG_SCHEME_ALL:  grp_on = '0;
            default:          grp_on = '1;
        endcase
    end

    // Enables change only while the source clock is low
    logic [NUM_GROUPS-1:0] gate_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gate_q <= '0;
        end else if (en_i && !src_clk && both_low) begin
            gate_q <= grp_on;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clk_out_o <= '0;
        end else if (en_i) begin
            // Gated groups held low, running ones share one source
            for (int i = 0; i < NUM_GROUPS; i++) begin
                clk_out_o[i] <= src_clk & gate_q[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            half_speed_o <= 1'b0;
        end else if (en_i) begin
            half_speed_o <= (spd_q == cpg_pkg::CPG_SPD_HALF);
        end
    end

    // =================================================================
    // Checks
    // =================================================================
    a_spd_switch_low: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && $changed(spd_q)) |-> (phase_q == 2'h0))
        else $error("Speed switched while a VCO clock was high");

    a_off_held_low: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (!gate_q[0]) |=> !clk_out_o[0])
        else $error("Shut-down output not held low");

    a_gate_change_low: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $changed(gate_q) |-> (phase_q == 2'h0) && (clk_out_o == '0))
        else $error("Gate changed outside the common low time");

    a_all_off_scheme: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && scheme_s == `CPG_SCHEME_ALL) [*8] |=> clk_out_o == '0)
        else $error("All-off scheme left an output running");

    a_half_follows: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && hs_s && both_low) |=> (spd_q == cpg_pkg::CPG_SPD_HALF))
        else $error("Half speed not taken at switch point");

    a_nom_follows: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (en_i && !hs_s && both_low) |=> (spd_q == cpg_pkg::CPG_SPD_NOM))
        else $error("Nominal speed not restored at switch point");

    a_in_phase: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        (gate_q[0] && gate_q[NUM_GROUPS-1]) |=>
            (clk_out_o[0] == clk_out_o[NUM_GROUPS-1]))
        else $error("Enabled outputs out of phase");

    // Every falling nominal edge is also an edge of the slow clock
    a_div_by_two: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $fell(nom_q) |-> $changed(div_q))
        else $error("Half-speed clock not aligned to nominal");

    // Request may only move on a rising edge of the slow clock
    a_hs_sync_slow: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $changed(hs_s) |-> (phase_q == 2'h2))
        else $error("Half-speed request taken off the slow clock rise");

    // Running output follows the clock chosen one edge before
    a_rate_follows: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        ($past(en_i) && $past(gate_q[NUM_GROUPS-1])) |->
            (clk_out_o[NUM_GROUPS-1] ==
             (($past(spd_q) == cpg_pkg::CPG_SPD_HALF) ? phase_q[1]
                                                       : phase_q[0])))
        else $error("Output rate does not follow selected speed");
endmodule : cpg_top

// ### tb/cpg_load_model.sv
/*
 * Clock load model: watches the group clocks as a load would.
 * Assumes clocks registered on clk_i; counts faults in bad_o.
 */
`timescale 1ns/1ps

module cpg_load_model #(
    parameter int NUM_GROUPS = 3
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  nrst_i,
    // Observed clocks
    input  wire logic [NUM_GROUPS-1:0] clk_in_i,
    input  wire logic                  half_i,
    // Fault count
    output int                         bad_o
);
    int                    hi_q [NUM_GROUPS];
    int                    stb_q;
    logic                  half_q;
    logic [NUM_GROUPS-1:0] prev_q;

    // High widths, speed stability and phase alignment of groups
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bad_o  <= 0;
            stb_q  <= 0;
            half_q <= 1'b0;
            prev_q <= '0;
            for (int g = 0; g < NUM_GROUPS; g++) hi_q[g] <= 0;
        end else begin
            half_q <= half_i;
            stb_q  <= (half_i != half_q) ? 0 : stb_q + 1;
            prev_q <= clk_in_i;
            if (prev_q != 0 && clk_in_i != 0 && clk_in_i != prev_q)
                bad_o <= bad_o + 1;
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (clk_in_i[g])
                    hi_q[g] <= hi_q[g] + 1;
                else if (hi_q[g] != 0) begin
                    hi_q[g] <= 0;
                    if (hi_q[g] > 2 || (stb_q > 8 && hi_q[g] != (half_i ? 2 : 1)))
                        bad_o <= bad_o + 1;
                end
            end
        end
    end
endmodule : cpg_load_model

// ### tb/cpg_bench.sv
/*
 * Self-checking bench of the clock output power gating block.
 * Assumes design files and the clock load model compile first.
 */
`timescale 1ns/1ps
`include "cpg_consts.svh"

module cpg_bench;
    logic       clk_i;
    logic       nrst_i;
    logic [1:0] group_off;
    logic       half_req;
    logic [2:0] clk_out;
    logic       half_o;
    logic       en;
    int         bad;
    int         err_total;
    int         num_checks;
    int         seed;
    int         r;
    int         idle_q [3];
    logic [3:0] exp_q [$];
    logic [3:0] last_q;
    logic [3:0] now_v;

    // =================================================================
    // Clock and instances
    // =================================================================
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    cpg_top #(.NUM_GROUPS(`CPG_NUM_GROUPS)) u_cpg_top (
        .clk_i               (clk_i),
        .nrst_i              (nrst_i),
        .en_i                (en),
        .output_group_off_i  (group_off),
        .half_speed_request_i(half_req),
        .clk_out_o           (clk_out),
        .half_speed_o        (half_o)
    );

    cpg_load_model #(.NUM_GROUPS(`CPG_NUM_GROUPS)) u_cpg_load_model (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .clk_in_i(clk_out),
        .half_i  (half_o),
        .bad_o   (bad)
    );

    // =================================================================
    // Checking
    // =================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    // Groups left running by each scheme
    function automatic logic [2:0] run_mask(input logic [1:0] s);
        case (s)
            `CPG_SCHEME_NONE: run_mask = 3'h7;
            `CPG_SCHEME_C:    run_mask = 3'h6;
            `CPG_SCHEME_BC:   run_mask = 3'h4;
            default:          run_mask = 3'h0;
        endcase
    endfunction : run_mask

    // Watcher: active groups and speed flag form one result
    always @(negedge clk_i) begin
        if (nrst_i) begin
            for (int g = 0; g < 3; g++) begin
                idle_q[g] = clk_out[g] ? 0 : (idle_q[g] < 9 ? idle_q[g] + 1 : 9);
                now_v[g+1] = idle_q[g] < 8;
            end
            now_v[0] = half_o;
            if (now_v !== last_q) begin
                last_q = now_v;
                if (exp_q.size() == 0) check(now_v, ~now_v);
                else check(now_v, exp_q.pop_front());
            end
        end
    end

    // =================================================================
    // Stimulus
    // =================================================================
    task automatic settle();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 30) begin
            @(negedge clk_i);
            n++;
        end
        repeat (12) @(negedge clk_i);
        if (exp_q.size() != 0) begin
            err_total++;
            print_verdict();
        end
    endtask : settle

    // One scheme or speed change at a time, expected result noted first
    task automatic apply(input logic [1:0] s, input logic h);
        if (s === group_off && h === half_req) return;
        exp_q.push_back({run_mask(s), h});
        group_off = s;
        half_req = h;
        settle();
    endtask : apply

    // Enable low during a common low time: outputs must stand still
    task automatic freeze();
        int         n;
        logic [3:0] held;
        n = 0;
        while (clk_out !== 3'h0 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        if (clk_out !== 3'h0) begin
            err_total++;
            print_verdict();
        end
        held = {clk_out, half_o};
        en = 1'b0;
        repeat (4) begin
            @(negedge clk_i);
            check({clk_out, half_o}, held);
        end
        en = 1'b1;
    endtask : freeze

    initial begin
        seed = 88;
        nrst_i = 1'b0;
        en = 1'b1;
        group_off = `CPG_SCHEME_NONE;
        half_req = 1'b0;
        last_q = 4'h0;
        for (int g = 0; g < 3; g++) idle_q[g] = 9;
        exp_q.push_back({run_mask(`CPG_SCHEME_NONE), 1'b0});
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        settle();
        apply(`CPG_SCHEME_C, 1'b0);
        apply(`CPG_SCHEME_BC, 1'b0);
        apply(`CPG_SCHEME_ALL, 1'b0);
        apply(`CPG_SCHEME_ALL, 1'b1);
        apply(`CPG_SCHEME_NONE, 1'b1);
        freeze();
        apply(`CPG_SCHEME_C, 1'b1);
        apply(`CPG_SCHEME_C, 1'b0);
        apply(`CPG_SCHEME_NONE, 1'b0);
        freeze();
        repeat (24) begin
            r = $random(seed);
            if (r[0]) apply(group_off, ~half_req);
            else apply(r[2:1], half_req);
        end
        repeat (20) @(negedge clk_i);
        check(bad, 0);
        print_verdict();
    end
endmodule : cpg_bench
